// file: dv/lpe_host_model.sv
`timescale 1ns/1ps

module lpe_host_model (
    // Clock
    input  wire logic        CORE_CLK,
    // Bus master side
    output logic [7:0]       ADDRESS,
    output logic             READ,
    output logic             WRITE,
    output logic [31:0]      WRITEDATA,
    input  wire logic [31:0] READDATA,
    input  wire logic        WAITREQUEST
);
    initial begin
        ADDRESS   = 8'h00;
        READ      = 1'b0;
        WRITE     = 1'b0;
        WRITEDATA = 32'h0;
    end

    // Held until waitrequest is seen low; idle bus shows inverted values
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge CORE_CLK);
        ADDRESS   <= a;
        READ      <= rd;
        WRITE     <= ~rd;
        WRITEDATA <= d;
        @(posedge CORE_CLK);
        while (WAITREQUEST !== 1'b0) @(posedge CORE_CLK);
        q = READDATA;
        READ      <= 1'b0;
        WRITE     <= 1'b0;
        ADDRESS   <= ~a;
        WRITEDATA <= ~d;
    endtask
endmodule

// file: dv/lpe_seq_checker.sv
`timescale 1ns/1ps
`include "lpe_regs.svh"

module lpe_seq_checker (
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST,
    // Register bus
    input wire logic [7:0]  ADDRESS,
    input wire logic        READ,
    input wire logic        WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [31:0] READDATA,
    input wire logic        WAITREQUEST,
    // Timebase and engines
    input wire logic        SLOW_CLOCK_INPUT,
    input wire logic [23:0] BRIGHTNESS,
    input wire logic [2:0]  PROGRAM_END_FLAG
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    logic stat_rd;
    assign stat_rd = READ && !WAITREQUEST && (ADDRESS == `LPE_STATUS_ADDR);

    sequence s_rd_open;
        READ && WAITREQUEST;
    endsequence
    sequence s_tick_step;
        $changed(BRIGHTNESS) && !$past(WRITE);
    endsequence

    property p_rd_first;
        READ && !$past(READ) |-> WAITREQUEST;
    endproperty
    property p_rd_second;
        s_rd_open ##1 READ |-> !WAITREQUEST;
    endproperty
    property p_wr_nowait;
        WRITE |-> !WAITREQUEST;
    endproperty
    property p_rd_stands;
        $changed(READDATA) |-> $past(READ);
    endproperty
    property p_flag_fall;
        |($past(PROGRAM_END_FLAG) & ~PROGRAM_END_FLAG) |-> stat_rd;
    endproperty
    property p_flag_report;
        stat_rd |-> READDATA[2:0] == $past(PROGRAM_END_FLAG);
    endproperty
    property p_flag_clear;
        stat_rd |=> (PROGRAM_END_FLAG & READDATA[2:0]) == 3'h0;
    endproperty
    // Engine levels move only on timebase ticks or after a bus write
    property p_bright_hold;
        s_tick_step |=> ($stable(BRIGHTNESS) || $past(WRITE))[*3];
    endproperty

    a_rd_first: assert property (p_rd_first) else $error("read did not stall first cycle");
    a_rd_second: assert property (p_rd_second) else $error("read stalled past second cycle");
    a_wr_nowait: assert property (p_wr_nowait) else $error("write was stalled");
    a_rd_stands: assert property (p_rd_stands) else $error("read data moved without a read");
    a_flag_fall: assert property (p_flag_fall) else $error("end flag fell without status read");
    a_flag_report: assert property (p_flag_report) else $error("status read shows unset flag");
    a_flag_clear: assert property (p_flag_clear) else $error("status read left flag set");
    a_bright_hold: assert property (p_bright_hold) else $error("brightness moved between ticks");
endmodule

bind lpe_sequencer lpe_seq_checker u_chk (
    .CORE_CLK         (CORE_CLK),
    .RST              (RST),
    .ADDRESS          (ADDRESS),
    .READ             (READ),
    .WRITE            (WRITE),
    .WRITEDATA        (WRITEDATA),
    .READDATA         (READDATA),
    .WAITREQUEST      (WAITREQUEST),
    .SLOW_CLOCK_INPUT (SLOW_CLOCK_INPUT),
    .BRIGHTNESS       (BRIGHTNESS),
    .PROGRAM_END_FLAG (PROGRAM_END_FLAG)
);

// file: dv/testbench.sv
`timescale 1ns/1ps
`include "lpe_regs.svh"

module testbench;
    logic        core_clk;
    logic        rst;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [4:0]  slow_cnt = 5'h00;
    logic [23:0] bright;
    logic [2:0]  end_flag;
    logic [31:0] rd_q;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    lpe_sequencer #(.SLOW_DIV(4)) u_dut (
        .CORE_CLK(core_clk), .RST(rst), .ADDRESS(address), .READ(read), .WRITE(write),
        .WRITEDATA(writedata), .READDATA(readdata), .WAITREQUEST(waitrequest),
        .SLOW_CLOCK_INPUT(slow_cnt[4]), .BRIGHTNESS(bright), .PROGRAM_END_FLAG(end_flag)
    );
    lpe_host_model u_host (
        .CORE_CLK(core_clk), .ADDRESS(address), .READ(read), .WRITE(write),
        .WRITEDATA(writedata), .READDATA(readdata), .WAITREQUEST(waitrequest)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        slow_cnt <= slow_cnt + 5'h01;
        cycles   <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_lvl(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b0, a, d, rd_q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        u_host.xfer(1'b1, a, 32'h0, rd_q);
        chk_reg(rd_q, exp);
    endtask
    task automatic prog(input int eng, input int idx, input logic [15:0] w);
        wr(`LPE_PROG_BASE + 8'(eng * 64 + idx * 4), {16'h0000, w});
    endtask
    task automatic wait_flag(input int idx);
        int n;
        n = 0;
        while (end_flag[idx] !== 1'b1 && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 4000) begin
            num_errors++;
            $display("BAD t=%0t flag=%h exp=%h", $time, end_flag, 3'(1 << idx));
        end
        // Flag rises once the end command has finished; idle twenty more ticks
        repeat (80) @(posedge core_clk);
    endtask

    task automatic t_reset_vals();
        rd_chk(`LPE_PROG_BASE + 8'h14, 32'h0);
        rd_chk(8'hfc, 32'h0);
        rd_chk(`LPE_CLKCFG_ADDR, {30'h0, `LPE_CLKCFG_RST});
        rd_chk(`LPE_PC1_ADDR, 32'h0);
        wr(8'h20, 32'h5);
        rd_chk(8'h20, 32'h0);
        chk_lvl(bright[7:0], 8'h00);
        $display("test reset_vals done");
    endtask

    task automatic t_set_end();
        prog(0, 0, 16'h405a);
        prog(0, 1, 16'hd000);
        wr(`LPE_ENABLE_ADDR, 32'h20);
        wait_flag(0);
        chk_lvl(bright[7:0], 8'h5a);
        rd_chk(`LPE_ENABLE_ADDR, 32'h0);
        rd_chk(`LPE_PC1_ADDR, 32'h0);
        rd_chk(`LPE_STATUS_ADDR, 32'h1);
        rd_chk(`LPE_STATUS_ADDR, 32'h0);
        $display("test set_end done");
    endtask

    task automatic t_ramp_down();
        prog(1, 0, 16'h4002);
        prog(1, 1, 16'h0184);
        prog(1, 2, 16'hd000);
        wr(`LPE_ENABLE_ADDR, 32'h08);
        wait_flag(1);
        chk_lvl(bright[15:8], 8'h00);
        rd_chk(`LPE_STATUS_ADDR, 32'h2);
        $display("test ramp_down done");
    endtask

    task automatic t_branch_loop();
        prog(2, 0, 16'h0101);
        prog(2, 1, 16'h0100);
        prog(2, 2, 16'ha180);
        prog(2, 3, 16'hd000);
        wr(`LPE_ENABLE_ADDR, 32'h02);
        wait_flag(2);
        chk_lvl(bright[23:16], 8'h08);
        rd_chk(`LPE_STATUS_ADDR, 32'h4);
        $display("test branch_loop done");
    endtask

    task automatic t_trigger();
        prog(0, 0, 16'he100);
        prog(0, 1, 16'h4011);
        prog(0, 2, 16'hd000);
        prog(1, 0, 16'he002);
        prog(1, 1, 16'hd000);
        wr(`LPE_ENABLE_ADDR, 32'h20);
        repeat (300) @(posedge core_clk);
        chk_lvl(bright[7:0], 8'h5a);
        wr(`LPE_ENABLE_ADDR, 32'h28);
        wait_flag(0);
        chk_lvl(bright[7:0], 8'h11);
        rd_chk(`LPE_STATUS_ADDR, 32'h3);
        $display("test trigger done");
    endtask

    task automatic t_step_log();
        wr(`LPE_PC3_ADDR, 32'hf);
        prog(2, 15, 16'h4033);
        wr(`LPE_ENABLE_ADDR, 32'h01);
        repeat (120) @(posedge core_clk);
        rd_chk(`LPE_PC3_ADDR, 32'h0);
        chk_lvl(bright[23:16], 8'h33);
        rd_chk(`LPE_ENABLE_ADDR, 32'h0);
        wr(`LPE_ENABLE_ADDR, 32'h40);
        @(posedge core_clk);
        chk_lvl(bright[23:16], 8'h0a);
        chk_lvl(bright[7:0], 8'h01);
        rd_chk(`LPE_BRIGHT_ADDR, 32'h0033_0011);
        $display("test step_log done");
    endtask

    task automatic t_once_zero();
        prog(0, 0, 16'h4077);
        prog(0, 1, 16'hd800);
        wr(`LPE_ENABLE_ADDR, 32'h30);
        repeat (120) @(posedge core_clk);
        rd_chk(`LPE_ENABLE_ADDR, 32'h0);
        rd_chk(`LPE_PC1_ADDR, 32'h1);
        chk_lvl(bright[7:0], 8'h77);
        wr(`LPE_ENABLE_ADDR, 32'h30);
        wait_flag(0);
        chk_lvl(bright[7:0], 8'h00);
        rd_chk(`LPE_PC1_ADDR, 32'h0);
        rd_chk(`LPE_STATUS_ADDR, 32'h1);
        $display("test once_zero done");
    endtask

    task automatic t_ext_clock();
        wr(`LPE_CLKCFG_ADDR, 32'h0);
        prog(1, 0, 16'h4044);
        prog(1, 1, 16'h0000);
        wr(`LPE_ENABLE_ADDR, 32'h04);
        repeat (200) @(posedge core_clk);
        rd_chk(`LPE_ENABLE_ADDR, 32'h04);
        repeat (500) @(posedge core_clk);
        rd_chk(`LPE_ENABLE_ADDR, 32'h0);
        rd_chk(`LPE_PC2_ADDR, 32'h1);
        chk_lvl(bright[15:8], 8'h44);
        wr(`LPE_ENABLE_ADDR, 32'h04);
        repeat (700) @(posedge core_clk);
        rd_chk(`LPE_PC2_ADDR, 32'h0);
        chk_lvl(bright[15:8], 8'h44);
        $display("test ext_clock done");
    endtask

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset_vals();
        t_set_end();
        t_ramp_down();
        t_branch_loop();
        t_trigger();
        t_step_log();
        t_once_zero();
        t_ext_clock();
        tally_and_finish();
    end
endmodule

// file: rtl/lpe_pkg.sv
package lpe_pkg;
    typedef enum logic [1:0] {
        EXEC_HOLD,
        EXEC_STEP,
        EXEC_RUN,
        EXEC_ONCE
    } lpe_exec_t;

    typedef enum logic [2:0] {
        OP_RAMP,
        OP_SET,
        OP_START,
        OP_BRANCH,
        OP_END,
        OP_TRIG
    } lpe_op_t;

    typedef struct packed {
        lpe_op_t    op;
        logic       prescale;
        logic [5:0] step_time;
        logic       down;
        logic [6:0] incr;
        logic [7:0] level;
        logic [5:0] loops;
        logic [3:0] target;
        logic       irq;
        logic       zero;
        logic [2:0] wait_mask;
        logic [2:0] send_mask;
    } lpe_cmd_t;
endpackage

// file: rtl/lpe_regs.svh
`ifndef LPE_REGS_SVH
`define LPE_REGS_SVH

// Register byte addresses
`define LPE_ENABLE_ADDR     8'h00
`define LPE_CLKCFG_ADDR     8'h04
`define LPE_STATUS_ADDR     8'h08
`define LPE_PC1_ADDR        8'h0c
`define LPE_PC2_ADDR        8'h10
`define LPE_PC3_ADDR        8'h14
`define LPE_BRIGHT_ADDR     8'h18
`define LPE_PROG_BASE       8'h40
`define LPE_PROG_TOP        8'hff

// Enable and clock config register fields
`define LPE_EN_EXEC3_LSB    0
`define LPE_EN_EXEC2_LSB    2
`define LPE_EN_EXEC1_LSB    4
`define LPE_EN_LOG_BIT      6
`define LPE_CLK_INT_BIT     0
`define LPE_CLK_DET_BIT     1

// Reset values
`define LPE_ENABLE_RST      8'h00
`define LPE_CLKCFG_RST      2'h1
`define LPE_PROG_RST        16'h0000

// Timing
`define LPE_CORE_HZ         10000000
`define LPE_SLOW_HZ         32768
`define LPE_SLOW_DIV        (`LPE_CORE_HZ / `LPE_SLOW_HZ)
`define LPE_PRE_SHORT       16
`define LPE_PRE_LONG        512
`define LPE_CMD_TICKS       16

`endif

// file: rtl/lpe_sequencer.sv
// Operation
// - three engines, own memories, shared triggers
// - each engine drives 8-bit brightness
// - timing from 32.7 kHz slow timebase
// - zero step time means set; zero word start
// - ramp fields: prescale, step, direction, count
// - prescale divides by 16 or 512
// - each step changes brightness by one
// - increment plus one steps; zero waits
// - saturate at 0/255, finish step count
// - log select maps brightness to its square over 256, nonzero to at least 1
// - set loads brightness from bits 7:0
// - non-ramp commands take sixteen ticks
// - go-to-start clears program counter
// - memory resets to zero words
// - branch loads target, loop count field
// - loop count repeats; zero loops forever
// - nested loops keep independent state
// - end clears counter, sets hold
// - end int flag, cleared by status read
// - end reset bit zeroes brightness
// - trigger send 16 ticks, wait stalls
// - latched triggers, cleared on matched wait
// - trigger masks bits 9:7 and 3:1
// - program counter wraps 15 to 0
// - sixteen 16-bit words per engine
`timescale 1ns/1ps
`include "lpe_regs.svh"

module lpe_sequencer #(
    parameter int unsigned NUM_ENG   = 3,
    parameter int unsigned PROG_WORDS = 16,
    parameter int unsigned SLOW_DIV  = `LPE_SLOW_DIV
) (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    // Avalon-MM slave
    input  wire logic [7:0]  ADDRESS,
    input  wire logic        READ,
    input  wire logic        WRITE,
    input  wire logic [31:0] WRITEDATA,
    output logic [31:0]      READDATA,
    output logic             WAITREQUEST,
    // Timebase
    input  wire logic        SLOW_CLOCK_INPUT,
    // Engine outputs
    output logic [23:0]      BRIGHTNESS,
    output logic [2:0]       PROGRAM_END_FLAG
);
    if (NUM_ENG != 3 || PROG_WORDS != 16 || SLOW_DIV < 2 || SLOW_DIV > 65536) begin : g_bad_params
        $error("lpe_sequencer: unsupported parameters");
    end

    function automatic lpe_pkg::lpe_cmd_t decode(input logic [15:0] w);
        lpe_pkg::lpe_cmd_t c;
        c = '0;
        c.prescale  = w[14];
        c.step_time = w[13:8];
        c.down      = w[7];
        c.incr      = w[6:0];
        c.level     = w[7:0];
        c.loops     = w[12:7];
        c.target    = w[3:0];
        c.irq       = w[12];
        c.zero      = w[11];
        c.wait_mask = w[9:7];
        c.send_mask = w[3:1];
        if (w == 16'h0000)
            c.op = lpe_pkg::OP_START;
        else if (!w[15] && w[13:8] == 6'h00)
            c.op = lpe_pkg::OP_SET;
        else if (!w[15])
            c.op = lpe_pkg::OP_RAMP;
        else if (w[14:13] == 2'b01)
            c.op = lpe_pkg::OP_BRANCH;
        else if (w[14:13] == 2'b10)
            c.op = lpe_pkg::OP_END;
        else if (w[14:13] == 2'b11)
            c.op = lpe_pkg::OP_TRIG;
        else
            c.op = lpe_pkg::OP_START;
        return c;
    endfunction

    function automatic logic [7:0] log_map(input logic [7:0] v);
        logic [15:0] sq;
        sq = 16'(v) * 16'(v);
        if (v == 8'h00)
            return 8'h00;
        return (sq[15:8] == 8'h00) ? 8'h01 : sq[15:8];
    endfunction

    // Registers
    logic [7:0]  enable_q;
    logic [1:0]  clkcfg_q;
    logic [2:0]  status_q;
    logic [15:0] prog_q [NUM_ENG][PROG_WORDS];
    logic [3:0]  pc_q [NUM_ENG];
    logic [7:0]  bright_q [NUM_ENG];
    logic [2:0]  trig_q [NUM_ENG];
    logic        rd_done_q;

    logic        bus_wr;
    logic        bus_rd;
    logic        sel_prog;
    logic [1:0]  prog_eng;
    logic [3:0]  prog_idx;
    assign bus_wr   = WRITE && !READ;
    assign bus_rd   = READ && !WRITE && !rd_done_q;
    assign sel_prog = ADDRESS >= `LPE_PROG_BASE;
    assign prog_eng = 2'((ADDRESS - `LPE_PROG_BASE) >> 6);
    assign prog_idx = ADDRESS[5:2];

    // slow timebase: internal divider or external input
    logic [15:0] div_q;
    logic        ext_s1_q;
    logic        ext_s2_q;
    logic        ext_s3_q;
    logic        tick;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            div_q    <= 16'h0000;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            div_q    <= (div_q == 16'(SLOW_DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
            ext_s1_q <= SLOW_CLOCK_INPUT;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    assign tick = clkcfg_q[`LPE_CLK_INT_BIT] ? (div_q == 16'h0000) : (ext_s2_q && !ext_s3_q);

    // prescaler: free-running count of timebase ticks
    logic [8:0] pre_q;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST)
            pre_q <= 9'h000;
        else if (tick)
            pre_q <= pre_q + 9'h001;
    end
    logic pre16;
    logic pre512;
    assign pre16  = tick && (pre_q[3:0] == 4'(`LPE_PRE_SHORT - 1));
    assign pre512 = tick && (pre_q == 9'(`LPE_PRE_LONG - 1));

    // Per-engine sequencer
    logic [2:0]  send_pulse [NUM_ENG];
    logic [2:0]  wait_clear [NUM_ENG];
    logic [2:0]  end_pulse;
    logic        exec_clr [NUM_ENG];

    genvar g;
    generate
        for (g = 0; g < NUM_ENG; g++) begin : g_eng
            typedef enum logic [1:0] { ST_IDLE, ST_EXEC, ST_WAITTRIG } lpe_st_t;
            lpe_st_t           st_q;
            lpe_pkg::lpe_cmd_t cmd_q;
            logic [5:0]        step_cnt_q;
            logic [6:0]        steps_left_q;
            logic [4:0]        fix_cnt_q;
            logic [5:0]        loop_q [PROG_WORDS];
            logic [1:0]        exec;
            logic              unit;
            lpe_pkg::lpe_cmd_t cur;
            logic              done;
            logic [3:0]        pc_next;

            assign exec = enable_q[`LPE_EN_EXEC1_LSB - 2*g +: 2];
            assign cur  = decode(prog_q[g][pc_q[g]]);
            assign unit = cmd_q.prescale ? pre512 : pre16;

            always_comb begin
                done    = 1'b0;
                pc_next = pc_q[g] + 4'h1;
                if (st_q == ST_EXEC) begin
                    case (cmd_q.op)
                        lpe_pkg::OP_RAMP:
                            done = unit && step_cnt_q == cmd_q.step_time - 6'h01 && steps_left_q == 7'h00;
                        default:
                            done = tick && fix_cnt_q == 5'(`LPE_CMD_TICKS - 2);
                    endcase
                end else if (st_q == ST_WAITTRIG) begin
                    // stall until all named triggers latched
                    done = tick && fix_cnt_q >= 5'(`LPE_CMD_TICKS - 2)
                           && (trig_q[g] & cmd_q.wait_mask) == cmd_q.wait_mask;
                end
                case (cmd_q.op)
                    lpe_pkg::OP_START,
                    lpe_pkg::OP_END:    pc_next = 4'h0;
                    lpe_pkg::OP_BRANCH:
                        if (cmd_q.loops == 6'h00 || loop_q[pc_q[g]] != cmd_q.loops)
                            pc_next = cmd_q.target;
                    default:            pc_next = pc_q[g] + 4'h1;
                endcase
            end

            assign send_pulse[g] = (done && cmd_q.op == lpe_pkg::OP_TRIG) ? cmd_q.send_mask : 3'h0;
            assign wait_clear[g] = (done && cmd_q.op == lpe_pkg::OP_TRIG) ? cmd_q.wait_mask : 3'h0;
            assign end_pulse[g]  = done && cmd_q.op == lpe_pkg::OP_END && cmd_q.irq;
            assign exec_clr[g]   = done && (cmd_q.op == lpe_pkg::OP_END || exec != lpe_pkg::EXEC_RUN);

            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    st_q         <= ST_IDLE;
                    cmd_q        <= '0;
                    step_cnt_q   <= 6'h00;
                    steps_left_q <= 7'h00;
                    fix_cnt_q    <= 5'h00;
                    pc_q[g]      <= 4'h0;
                    bright_q[g]  <= 8'h00;
                    for (int i = 0; i < PROG_WORDS; i++)
                        loop_q[i] <= 6'h00;
                end else begin
                    case (st_q)
                        ST_IDLE: begin
                            if (exec != lpe_pkg::EXEC_HOLD && tick) begin
                                cmd_q        <= cur;
                                step_cnt_q   <= 6'h00;
                                steps_left_q <= cur.incr;
                                fix_cnt_q    <= 5'h00;
                                st_q         <= (cur.op == lpe_pkg::OP_TRIG && cur.wait_mask != 3'h0)
                                                ? ST_WAITTRIG : ST_EXEC;
                                if (cur.op == lpe_pkg::OP_SET)
                                    bright_q[g] <= cur.level;
                            end else if (bus_wr && !sel_prog && ADDRESS == 8'(`LPE_PC1_ADDR + 4*g)) begin
                                pc_q[g] <= WRITEDATA[3:0];
                            end
                        end
                        ST_EXEC,
                        ST_WAITTRIG: begin
                            if (tick && fix_cnt_q != 5'h1f)
                                fix_cnt_q <= fix_cnt_q + 5'h01;
                            if (st_q == ST_EXEC && cmd_q.op == lpe_pkg::OP_RAMP && unit) begin
                                if (step_cnt_q == cmd_q.step_time - 6'h01) begin
                                    step_cnt_q <= 6'h00;
                                    if (steps_left_q != 7'h00)
                                        steps_left_q <= steps_left_q - 7'h01;
                                    // one per step, saturating, zero incr waits
                                    if (cmd_q.incr != 7'h00) begin
                                        if (cmd_q.down && bright_q[g] != 8'h00)
                                            bright_q[g] <= bright_q[g] - 8'h01;
                                        else if (!cmd_q.down && bright_q[g] != 8'hff)
                                            bright_q[g] <= bright_q[g] + 8'h01;
                                    end
                                end else begin
                                    step_cnt_q <= step_cnt_q + 6'h01;
                                end
                            end
                            if (done) begin
                                st_q    <= ST_IDLE;
                                pc_q[g] <= pc_next;
                                if (cmd_q.op == lpe_pkg::OP_END && cmd_q.zero)
                                    bright_q[g] <= 8'h00;
                                if (cmd_q.op == lpe_pkg::OP_BRANCH && cmd_q.loops != 6'h00)
                                    loop_q[pc_q[g]] <= (loop_q[pc_q[g]] != cmd_q.loops)
                                                       ? loop_q[pc_q[g]] + 6'h01 : 6'h00;
                            end
                        end
                        default: st_q <= ST_IDLE;
                    endcase
                end
            end

            // latch incoming sends, clear on matched wait
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST)
                    trig_q[g] <= 3'h0;
                else
                    trig_q[g] <= (trig_q[g] & ~wait_clear[g])
                                 | {send_pulse[2][g], send_pulse[1][g], send_pulse[0][g]};
            end

            assign BRIGHTNESS[8*g +: 8] = enable_q[`LPE_EN_LOG_BIT] ? log_map(bright_q[g]) : bright_q[g];
        end
    endgenerate

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int e = 0; e < NUM_ENG; e++)
                for (int i = 0; i < PROG_WORDS; i++)
                    prog_q[e][i] <= `LPE_PROG_RST;
        end else if (bus_wr && sel_prog && prog_eng != 2'h3) begin
            prog_q[prog_eng][prog_idx] <= WRITEDATA[15:0];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            enable_q <= `LPE_ENABLE_RST;
            clkcfg_q <= `LPE_CLKCFG_RST;
        end else begin
            if (bus_wr && ADDRESS == `LPE_ENABLE_ADDR)
                enable_q <= WRITEDATA[7:0];
            else
                for (int e = 0; e < NUM_ENG; e++)
                    if (exec_clr[e])
                        enable_q[`LPE_EN_EXEC1_LSB - 2*e +: 2] <= 2'b00;
            if (bus_wr && ADDRESS == `LPE_CLKCFG_ADDR)
                clkcfg_q <= WRITEDATA[1:0];
        end
    end

    // sticky end flag, set wins over read clear
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST)
            status_q <= 3'h0;
        else if (bus_rd && ADDRESS == `LPE_STATUS_ADDR)
            status_q <= end_pulse;
        else
            status_q <= status_q | end_pulse;
    end
    assign PROGRAM_END_FLAG = status_q;

    // Bus answer: reads take one wait cycle
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            rd_done_q <= 1'b0;
            READDATA  <= 32'h0000_0000;
        end else begin
            rd_done_q <= bus_rd;
            if (bus_rd) begin
                case (ADDRESS)
                    `LPE_ENABLE_ADDR: READDATA <= {24'h0, enable_q};
                    `LPE_CLKCFG_ADDR: READDATA <= {30'h0, clkcfg_q};
                    `LPE_STATUS_ADDR: READDATA <= {29'h0, status_q};
                    `LPE_PC1_ADDR:    READDATA <= {28'h0, pc_q[0]};
                    `LPE_PC2_ADDR:    READDATA <= {28'h0, pc_q[1]};
                    `LPE_PC3_ADDR:    READDATA <= {28'h0, pc_q[2]};
                    `LPE_BRIGHT_ADDR: READDATA <= {8'h0, bright_q[2], bright_q[1], bright_q[0]};
                    default:
                        READDATA <= (sel_prog && prog_eng != 2'h3) ? {16'h0, prog_q[prog_eng][prog_idx]} : 32'h0;
                endcase
            end
        end
    end
    assign WAITREQUEST = READ && !rd_done_q;
endmodule
